// *** rtl/radio_spi_config_port.sv ***
// Purpose: serial slave port for register, strobe and FIFO access of the radio
// Assumes: serial clock idles low, data sampled on its rising edge
// Notes: pins pass three flip-flops; the serial clock is found by sampling
`timescale 1ns/1ps
`default_nettype none
// Notes on behaviour
// R1 - Host rewrites registers differing from defaults
// R2 - Slave only; bytes shift MSB first
// R3 - Header: rw flag, burst flag, address
// R4 - Chip select high abandons partial transfer
// R5 - Host waits for data-out low first
// R6 - Select while awake drives data-out low
// R7 - Host keeps serial clock rate limits
// R8 - Blind host waits 150 us at wake
// R9 - Status byte shifts out with header and write bytes
// R10 - Bit 7 ready flag, low when stable
// R11 - Bits 6:4 carry main radio state
// R12 - Transitional states may report idle
// R13 - Idle keeps oscillator and core powered
// R14 - Host changes frequency only in idle
// R15 - Count: rx bytes if read, else free
// R16 - Count saturates at fifteen
// R17 - Host drains rx then flushes on overrun; the bench flushes rx on overrun without draining it first
// R18 - Host flushes tx on underrun
// R19 - Idle is 000, synth ready 011
// R20 - Burst address increments per completed byte
// R21 - Address 0x3F maps to the data FIFOs
module radio_spi_config_port import radio_spi_pkg::*; #(
    parameter int CNT_W = 7,
    parameter int FIFO_DEPTH = 8
) (
    input wire logic sys_clk,
    input wire logic reset_n,
    input wire logic serialClk,
    input wire logic chipSelectN,
    input wire logic serialIn,
    output logic serialOut,
    output logic serialOutEn,
    input wire logic crystalStable,
    input wire radio_state_t radioState,
    input wire logic transitional,
    input wire logic [CNT_W-1:0] rxCount,
    input wire logic [CNT_W-1:0] txFree,
    output logic [ADDR_W-1:0] regAddr,
    output logic [BYTE_W-1:0] regWrData,
    output logic regWr,
    output logic regRd,
    input wire logic [BYTE_W-1:0] regRdData,
    output logic cmdStrobe,
    output logic cmdRw,
    output logic [BYTE_W-1:0] txData,
    output logic txValid,
    input wire logic txReady,
    output logic txDropped
);
    if (CNT_W < 4) begin : g_bad_cnt
        $error("radio_spi_config_port: CNT_W must be at least 4");
    end

    // Pin synchronisers: a level changes once stages two and three agree
    logic [2:0] pinRaw, s1_q, s2_q, s3_q, lvl_q;
    assign pinRaw = {serialClk, chipSelectN, serialIn};
    for (genvar i = 0; i < $bits(pinRaw); i++) begin : g_sync
        always_ff @(posedge sys_clk or negedge reset_n) begin
            if (!reset_n) begin
                s1_q[i] <= PIN_RESET[i];
                s2_q[i] <= PIN_RESET[i];
                s3_q[i] <= PIN_RESET[i];
                lvl_q[i] <= PIN_RESET[i];
            end else begin
                s1_q[i] <= pinRaw[i];
                s2_q[i] <= s1_q[i];
                s3_q[i] <= s2_q[i];
                if (s2_q[i] == s3_q[i]) begin
                    lvl_q[i] <= s3_q[i];
                end
            end
        end
    end

    logic sclkRise, sclkFall, csLow, siBit;
    assign sclkRise = !lvl_q[PIN_SCLK] && s2_q[PIN_SCLK] && s3_q[PIN_SCLK];
    assign sclkFall = lvl_q[PIN_SCLK] && !s2_q[PIN_SCLK] && !s3_q[PIN_SCLK];
    assign csLow = !lvl_q[PIN_CS];
    assign siBit = s3_q[PIN_SI];

    phase_t phase_q;
    logic [BIT_IDX_W-1:0] bitIdx_q;
    logic [BYTE_W-2:0] rxShift_q;
    logic hdrRw_q, burst_q, started_q;
    logic [ADDR_W-1:0] addr_q;
    logic [BYTE_W-1:0] readData_q;
    logic byteDone, isStrobe, fifoAddr, wantRd;
    logic [BYTE_W-1:0] inByte, statusByte, curByte;
    logic [ADDR_W-1:0] nextAddr;
    logic [2:0] stateField;
    logic [CNT_W-1:0] rawCount;
    logic [3:0] satCount;
    byte_fifo_if #(.WIDTH(BYTE_W)) txq ();
    logic pushValid_q;
    logic [BYTE_W-1:0] pushData_q;

    assign byteDone = csLow && sclkRise && bitIdx_q == LAST_BIT;
    assign inByte = {rxShift_q, siBit}; // R2
    assign isStrobe = !inByte[HDR_BURST_BIT] && inByte[ADDR_W-1:0] >= STROBE_LO
        && inByte[ADDR_W-1:0] <= STROBE_HI;
    assign fifoAddr = addr_q == FIFO_ADDR; // R21
    // R20 R21
    assign nextAddr = (phase_q == PH_HEADER) ? inByte[ADDR_W-1:0]
        : (fifoAddr ? addr_q : addr_q + 1'b1);
    assign wantRd = (phase_q == PH_HEADER && inByte[HDR_RW_BIT] && !isStrobe)
        || (phase_q == PH_READ && burst_q);

    // Status byte is rebuilt live so the count follows the header's rw flag
    always_comb begin
        stateField = radioState; // R11 R19
        if (transitional && (radioState == ST_CALIBRATE || radioState == ST_SETTLING)) begin
            stateField = ST_IDLE; // R12
        end
        rawCount = hdrRw_q ? rxCount : txFree; // R15
        satCount = (rawCount >= CNT_W'(COUNT_SAT)) ? COUNT_SAT : rawCount[3:0]; // R16
        statusByte = {!crystalStable, stateField, satCount}; // R10 R13
        curByte = (phase_q == PH_READ) ? readData_q : statusByte; // R9
    end

    // Frame sequencing: header, then data bytes; select high restarts it
    always_ff @(posedge sys_clk or negedge reset_n) begin
        if (!reset_n) begin
            phase_q <= PH_HEADER;
            bitIdx_q <= '0;
            rxShift_q <= '0;
            hdrRw_q <= 1'b0;
            burst_q <= 1'b0;
            addr_q <= '0;
            started_q <= 1'b0;
        end else if (!csLow) begin
            phase_q <= PH_HEADER; // R4
            bitIdx_q <= '0;
            started_q <= 1'b0;
        end else if (sclkRise) begin
            bitIdx_q <= bitIdx_q + 1'b1;
            rxShift_q <= inByte[BYTE_W-2:0];
            started_q <= 1'b1;
            if (phase_q == PH_HEADER && bitIdx_q == '0) begin
                hdrRw_q <= siBit;
            end
            if (bitIdx_q == LAST_BIT) begin
                addr_q <= nextAddr; // R20
                if (phase_q == PH_HEADER) begin
                    burst_q <= inByte[HDR_BURST_BIT];
                    if (!isStrobe) begin
                        phase_q <= inByte[HDR_RW_BIT] ? PH_READ : PH_WRITE;
                    end
                end else if (!burst_q) begin
                    phase_q <= PH_HEADER;
                end
            end
        end
    end

    // Requests toward the core, issued only for completed bytes
    always_ff @(posedge sys_clk or negedge reset_n) begin
        if (!reset_n) begin
            regWr <= 1'b0;
            regRd <= 1'b0;
            cmdStrobe <= 1'b0;
            cmdRw <= 1'b0;
            regAddr <= '0;
            regWrData <= '0;
            pushValid_q <= 1'b0;
            pushData_q <= '0;
        end else begin
            regWr <= byteDone && phase_q == PH_WRITE && !fifoAddr; // R4
            pushValid_q <= byteDone && phase_q == PH_WRITE && fifoAddr; // R21
            regRd <= byteDone && wantRd;
            cmdStrobe <= byteDone && phase_q == PH_HEADER && isStrobe;
            if (byteDone) begin
                regAddr <= (phase_q == PH_WRITE) ? addr_q : nextAddr;
                regWrData <= inByte;
                pushData_q <= inByte;
                cmdRw <= inByte[HDR_RW_BIT];
            end
        end
    end

    always_ff @(posedge sys_clk or negedge reset_n) begin
        if (!reset_n) begin
            readData_q <= '0;
        end else if (regRd) begin
            readData_q <= regRdData;
        end
    end

    // Data out: refreshed until the first clock, then changes on falling edges
    always_ff @(posedge sys_clk or negedge reset_n) begin
        if (!reset_n) begin
            serialOut <= 1'b0;
            serialOutEn <= 1'b0;
        end else if (!csLow) begin
            serialOut <= 1'b0;
            serialOutEn <= 1'b0;
        end else begin
            serialOutEn <= 1'b1;
            if (sclkFall || (!started_q && !lvl_q[PIN_SCLK])) begin
                serialOut <= curByte[~bitIdx_q]; // R2 R6 R9 R10
            end
        end
    end

    // A full FIFO drops the byte and flags it for one cycle
    always_ff @(posedge sys_clk or negedge reset_n) begin
        if (!reset_n) begin
            txDropped <= 1'b0;
        end else begin
            txDropped <= pushValid_q && !txq.inReady;
        end
    end

    assign txq.inValid = pushValid_q;
    assign txq.inData = pushData_q;
    assign txq.outReady = txReady;
    assign txData = txq.outData;
    assign txValid = txq.outValid;

    byte_fifo #(.WIDTH(BYTE_W), .DEPTH(FIFO_DEPTH)) u_txq (
        .sys_clk(sys_clk),
        .reset_n(reset_n),
        .port(txq.store)
    );

    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (!reset_n);

    sequence s_wrByte;
        byteDone && phase_q == PH_WRITE && !fifoAddr;
    endsequence
    sequence s_burstByte;
        byteDone && phase_q != PH_HEADER && burst_q && !fifoAddr;
    endsequence

    a_quiet_deselected: assert property (!csLow |=> !serialOutEn && !serialOut) // R4
        else $error("data-out active while deselected");
    a_abort_no_req: assert property (!csLow |=> !regWr && !regRd && !cmdStrobe) // R4
        else $error("request issued outside a frame");
    a_ready_drive_low: assert property (csLow && !started_q && !lvl_q[PIN_SCLK]
        && crystalStable |=> serialOutEn && !serialOut) // R6
        else $error("data-out not low while awake and selected");
    a_not_ready_high: assert property (csLow && !started_q && !lvl_q[PIN_SCLK]
        && !crystalStable |=> serialOut) // R10
        else $error("ready flag low before crystal stable");
    a_write_msb_first: assert property (s_wrByte |=> regWr && regWrData == $past(inByte)) // R2
        else $error("written byte not assembled msb first");
    a_burst_increment: assert property (s_burstByte |=> addr_q == $past(addr_q) + 1'b1) // R20
        else $error("burst address did not advance by one");
    a_fifo_route: assert property (byteDone && phase_q == PH_WRITE && fifoAddr
        |=> pushValid_q && !regWr) // R21
        else $error("fifo write not routed to the fifo");
    a_count_saturate: assert property (hdrRw_q && rxCount >= CNT_W'(COUNT_SAT)
        |-> statusByte[3:0] == COUNT_SAT) // R15 R16
        else $error("receive count not saturated");
    a_state_report: assert property (!transitional |-> statusByte[6:4] == radioState) // R11
        else $error("state field differs from radio state");
    a_transit_idle: assert property (transitional
        && (radioState == ST_SETTLING || radioState == ST_CALIBRATE)
        |-> statusByte[6:4] == ST_IDLE) // R12
        else $error("transitional state not reported idle");
    a_idle_awake: assert property (radioState == ST_IDLE && crystalStable
        |-> !statusByte[7] && statusByte[6:4] == ST_IDLE) // R13
        else $error("idle state not reported ready");
endmodule // radio_spi_config_port
`default_nettype wire

// *** rtl/radio_spi_pkg.sv ***
// Purpose: shared constants and types of the radio serial configuration port
// Assumes: serial mode 0, most significant bit first
// Notes: status byte = ready flag, state field, saturated FIFO count
package radio_spi_pkg;
    localparam int BYTE_W = 8;
    localparam int ADDR_W = 6;
    localparam int BIT_IDX_W = 3;
    localparam logic [BIT_IDX_W-1:0] LAST_BIT = 3'h7;
    localparam int HDR_RW_BIT = 7;
    localparam int HDR_BURST_BIT = 6;
    localparam logic [ADDR_W-1:0] FIFO_ADDR = 6'h3f;
    localparam logic [ADDR_W-1:0] STROBE_LO = 6'h30;
    localparam logic [ADDR_W-1:0] STROBE_HI = 6'h3d;
    localparam logic [3:0] COUNT_SAT = 4'hf;
    localparam int SYNC_STAGES = 3;
    // Pin order in the synchroniser: serial clock, chip select, serial in
    localparam int PIN_SCLK = 2;
    localparam int PIN_CS = 1;
    localparam int PIN_SI = 0;
    localparam logic [2:0] PIN_RESET = 3'h2;

    typedef enum logic [2:0] {
        ST_IDLE = 3'h0,
        ST_RX = 3'h1,
        ST_TX = 3'h2,
        ST_TX_SYNTH_READY = 3'h3,
        ST_CALIBRATE = 3'h4,
        ST_SETTLING = 3'h5,
        ST_RX_OVERRUN = 3'h6,
        ST_TX_UNDERRUN = 3'h7
    } radio_state_t;

    typedef enum {PH_HEADER, PH_WRITE, PH_READ} phase_t;
endpackage

// *** rtl/byte_fifo_if.sv ***
// Purpose: carrier between the serial port and its transmit byte FIFO
// Assumes: valid and ready handshake on both sides
// Notes: fill side is the serial port, drain side leaves the block
`timescale 1ns/1ps
`default_nettype none
interface byte_fifo_if #(parameter int WIDTH = 8);
    logic [WIDTH-1:0] inData;
    logic inValid;
    logic inReady;
    logic [WIDTH-1:0] outData;
    logic outValid;
    logic outReady;
    modport source (output inData, output inValid, input inReady,
        input outData, input outValid, output outReady);
    modport store (input inData, input inValid, output inReady,
        output outData, output outValid, input outReady);
endinterface
`default_nettype wire

// *** rtl/byte_fifo.sv ***
// Purpose: small FIFO with registered read data for transmit bytes
// Assumes: DEPTH is a power of two, at least 2
// Notes: words pass the memory and then an output register; both count toward DEPTH
`timescale 1ns/1ps
`default_nettype none
module byte_fifo #(
    parameter int WIDTH = 8,
    parameter int DEPTH = 8
) (
    input wire logic sys_clk,
    input wire logic reset_n,
    byte_fifo_if.store port
);
    localparam int PTR_W = $clog2(DEPTH);
    localparam logic [PTR_W:0] DEPTH_CNT = (PTR_W+1)'(DEPTH);

    if (DEPTH < 2 || (1 << PTR_W) != DEPTH) begin : g_bad_depth
        $error("byte_fifo: DEPTH must be a power of two of at least 2");
    end

    logic [WIDTH-1:0] mem [DEPTH];
    logic [PTR_W-1:0] wrPtr_q, rdPtr_q;
    logic [PTR_W:0] count_q;
    logic [WIDTH-1:0] outData_q;
    logic outValid_q;
    logic doIn, loadOut;

    assign doIn = port.inValid && port.inReady;
    assign loadOut = (!outValid_q || port.outReady) && (count_q != '0);
    // The output register holds a word too, so full means DEPTH words in all
    assign port.inReady = (count_q + (PTR_W+1)'(outValid_q)) != DEPTH_CNT;
    assign port.outData = outData_q;
    assign port.outValid = outValid_q;

    always_ff @(posedge sys_clk) begin
        if (doIn) begin
            mem[wrPtr_q] <= port.inData;
        end
    end

    always_ff @(posedge sys_clk or negedge reset_n) begin
        if (!reset_n) begin
            wrPtr_q <= '0;
            rdPtr_q <= '0;
            count_q <= '0;
        end else begin
            if (doIn) begin
                wrPtr_q <= wrPtr_q + 1'b1;
            end
            if (loadOut) begin
                rdPtr_q <= rdPtr_q + 1'b1;
            end
            count_q <= count_q + (PTR_W+1)'(doIn) - (PTR_W+1)'(loadOut);
        end
    end

    // Output register drains the memory whenever it is empty or being taken
    always_ff @(posedge sys_clk or negedge reset_n) begin
        if (!reset_n) begin
            outData_q <= '0;
            outValid_q <= 1'b0;
        end else if (loadOut) begin
            outData_q <= mem[rdPtr_q];
            outValid_q <= 1'b1;
        end else if (port.outReady) begin
            outValid_q <= 1'b0;
        end
    end
endmodule // byte_fifo
`default_nettype wire

// *** sim/spi_host_model.sv ***
// Purpose: host side of the four-wire serial link, clocking bytes in and out
// Assumes: serial clock idles low, device samples on the rise
// Notes: data-out is read late in the high phase, after the device's lag
`timescale 1ns/1ps
`default_nettype none
module spi_host_model (
    output var logic serialClk,
    output var logic chipSelectN,
    output var logic serialIn,
    input wire logic soLine
);
    initial begin
        serialClk = 1'b0;
        chipSelectN = 1'b1;
        serialIn = 1'b0;
    end
    task automatic select(input bit waitRdy, output bit ok);
        int i;
        chipSelectN = 1'b0;
        ok = !waitRdy;
        if (!waitRdy) #150000;
        for (i = 0; i < 40 && !ok; i++) begin
            #8;
            if (soLine === 1'b0) ok = 1'b1;
        end
    endtask
    task automatic xfer(input logic [7:0] tx, input int nb, output logic [7:0] rx);
        int i;
        rx = 8'h00;
        for (i = 7; i >= 8 - nb; i--) begin
            serialIn = tx[i];
            #32 serialClk = 1'b1;
            #30 rx[i] = soLine;
            #2 serialClk = 1'b0;
        end
        #100;
    endtask
    task automatic deselect();
        #32 chipSelectN = 1'b1;
        serialIn = ~serialIn;
        #96;
    endtask
endmodule // spi_host_model
`default_nettype wire

// *** sim/radio_spi_config_port_tb_top.sv ***
// Purpose: self-checking bench of the radio serial configuration port
// Assumes: core side levels are set by the bench on the falling clock edge
// Notes: undriven data-out is seen high so a deselected line never looks ready
`timescale 1ns/1ps
`default_nettype none
module radio_spi_config_port_tb_top import radio_spi_pkg::*; ;
    logic sys_clk, reset_n, crystalStable, transitional, txReady;
    logic serialClk, chipSelectN, serialIn, serialOut, serialOutEn;
    radio_state_t radioState;
    logic [6:0] rxCount, txFree;
    logic [5:0] regAddr;
    logic [7:0] regWrData, regRdData, txData, rx;
    logic regWr, regRd, cmdStrobe, cmdRw, txValid, txDropped, soLine, ok;
    logic [13:0] wrQ[$];
    logic [5:0] rdQ[$];
    logic [6:0] stbQ[$];
    // Stand-in flush strobe codes of the bench core
    localparam logic [5:0] FLUSH_RX_ADDR = 6'h38;
    localparam logic [5:0] FLUSH_TX_ADDR = 6'h39;
    logic [7:0] txQ[$];
    int miscompares = 0, compares = 0, drops = 0;
    assign soLine = serialOutEn ? serialOut : 1'b1;
    radio_spi_config_port uut (.sys_clk(sys_clk), .reset_n(reset_n),
        .serialClk(serialClk), .chipSelectN(chipSelectN), .serialIn(serialIn),
        .serialOut(serialOut), .serialOutEn(serialOutEn), .crystalStable(crystalStable),
        .radioState(radioState), .transitional(transitional), .rxCount(rxCount),
        .txFree(txFree), .regAddr(regAddr), .regWrData(regWrData), .regWr(regWr),
        .regRd(regRd), .regRdData(regRdData), .cmdStrobe(cmdStrobe), .cmdRw(cmdRw),
        .txData(txData), .txValid(txValid), .txReady(txReady), .txDropped(txDropped));
    spi_host_model host (.serialClk(serialClk), .chipSelectN(chipSelectN),
        .serialIn(serialIn), .soLine(soLine));
    initial begin
        sys_clk = 1'b0;
        forever #4 sys_clk = ~sys_clk;
    end
    // Register file stand-in: read data follows the address
    always @(negedge sys_clk) regRdData <= {2'h2, regAddr};
    always @(posedge sys_clk) begin
        if (regWr === 1'b1) wrQ.push_back({regAddr, regWrData});
        if (regRd === 1'b1) rdQ.push_back(regAddr);
        if (cmdStrobe === 1'b1) stbQ.push_back({cmdRw, regAddr});
        if (txDropped === 1'b1) drops++;
        if (txValid === 1'b1 && txReady === 1'b1) txQ.push_back(txData);
    end
    function automatic logic [7:0] stat(input logic rw);
        logic [2:0] s;
        logic [6:0] c;
        s = radioState;
        if (transitional && (s == ST_CALIBRATE || s == ST_SETTLING)) s = ST_IDLE;
        c = rw ? rxCount : txFree;
        return {~crystalStable, s, (c > 7'd15) ? COUNT_SAT : c[3:0]};
    endfunction
    task automatic check(input logic [15:0] seen, input logic [15:0] exp);
        compares++;
        if (seen !== exp) begin
            miscompares++;
            $display("[ERR] %0t mismatch seen %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic open(input bit waitRdy);
        host.select(waitRdy, ok);
        check(ok, 1'b1);
        check(serialOutEn, 1'b1);
    endtask
    task automatic status_scan();
        int k;
        logic [5:0] fl;
        txFree = 7'd20;
        rxCount = 7'd9;
        for (k = 0; k < 8; k++) begin
            fl = (k == 6) ? FLUSH_RX_ADDR : FLUSH_TX_ADDR;
            @(negedge sys_clk) radioState = radio_state_t'(k);
            open(1);
            host.xfer({2'h0, STROBE_LO + 6'(k)}, 8, rx);
            check(rx, stat(1'b0));
            if (k >= 6) host.xfer({2'h0, fl}, 8, rx);
            if (k >= 6) check(rx, stat(1'b0));
            host.deselect();
            check(stbQ.size(), (k >= 6) ? 2 : 1);
            if (stbQ.size() > 0) check(stbQ.pop_front(), {1'b0, STROBE_LO + 6'(k)});
            if (k >= 6 && stbQ.size() > 0) check(stbQ.pop_front(), {1'b0, fl});
        end
        @(negedge sys_clk) begin radioState = ST_CALIBRATE; transitional = 1'b1; end
        open(1);
        host.xfer({2'h2, STROBE_LO}, 8, rx);
        check(rx, stat(1'b1));
        host.deselect();
        check(stbQ.size(), 1);
        if (stbQ.size() > 0) check(stbQ.pop_front(), {1'b1, STROBE_LO});
        @(negedge sys_clk) crystalStable = 1'b0;
        host.select(0, ok);
        host.xfer({2'h0, STROBE_LO}, 8, rx);
        check(rx[7], 1'b1);
        host.deselect();
        @(negedge sys_clk) begin crystalStable = 1'b1; transitional = 1'b0; end
        stbQ.delete();
    endtask
    task automatic write_abort();
        @(negedge sys_clk) radioState = ST_IDLE;
        open(1);
        host.xfer(8'h05, 8, rx);
        check(rx, stat(1'b0));
        host.xfer(8'ha5, 8, rx);
        check(rx, stat(1'b0));
        host.deselect();
        open(1);
        host.xfer(8'h06, 4, rx);
        host.deselect();
        open(1);
        host.xfer(8'h07, 8, rx);
        host.xfer(8'h3c, 8, rx);
        host.deselect();
        check(wrQ.size(), 2);
        if (wrQ.size() == 2) check(wrQ[0], {6'h05, 8'ha5});
        if (wrQ.size() == 2) check(wrQ[1], {6'h07, 8'h3c});
        open(1);
        host.xfer(8'h85, 8, rx);
        check(rx, stat(1'b1));
        host.xfer(8'h00, 8, rx);
        check(rx, 8'h85);
        host.xfer(8'h09, 8, rx);
        host.xfer(8'h5a, 8, rx);
        host.deselect();
        check(wrQ.size(), 3);
        if (wrQ.size() == 3) check(wrQ[2], {6'h09, 8'h5a});
    endtask
    task automatic burst_read(input logic [5:0] a, input logic [5:0] step);
        int j;
        rdQ.delete();
        open(1);
        host.xfer({2'h3, a}, 8, rx);
        check(rx, stat(1'b1));
        for (j = 0; j < 3; j++) begin
            host.xfer(8'h00, 8, rx);
            check(rx, {2'h2, a + step * 6'(j)});
        end
        host.deselect();
        check(rdQ.size() >= 3, 1'b1);
        for (j = 0; j < 3 && j < rdQ.size(); j++) check(rdQ[j], a + step * 6'(j));
    endtask
    task automatic fifo_fill();
        int j;
        @(negedge sys_clk) txReady = 1'b0;
        open(1);
        host.xfer({2'h1, FIFO_ADDR}, 8, rx);
        for (j = 0; j < 10; j++) host.xfer(8'(j), 8, rx);
        host.deselect();
        check(drops, 2);
        @(negedge sys_clk) txReady = 1'b1;
        for (j = 0; j < 60 && txQ.size() < 8; j++) @(posedge sys_clk);
        repeat (4) @(posedge sys_clk);
        check(txQ.size(), 8);
        for (j = 0; j < 8 && j < txQ.size(); j++) check(txQ[j], 8'(j));
    endtask
    task automatic summarize();
        if (miscompares == 0 && compares > 0) $display("TB: PASS");
        else $display("TB: FAIL");
        $finish;
    endtask
    initial begin
        reset_n = 1'b0;
        crystalStable = 1'b1;
        transitional = 1'b0;
        txReady = 1'b1;
        radioState = ST_IDLE;
        rxCount = 7'd0;
        txFree = 7'd0;
        repeat (5) @(negedge sys_clk);
        reset_n = 1'b1;
        repeat (6) @(negedge sys_clk);
        status_scan();
        write_abort();
        burst_read(6'h0a, 6'h01);
        burst_read(FIFO_ADDR, 6'h00);
        fifo_fill();
        summarize();
    end
endmodule // radio_spi_config_port_tb_top
`default_nettype wire
